// ---- cbt_ops_map.vh ----
// constants for the compare, batch and table datapath
`ifndef CBT_OPS_MAP_VH
`define CBT_OPS_MAP_VH

`define CBT_WORD_W 16
`define CBT_DINT_W 32
`define CBT_CNT_W 9
`define CBT_OP_W 4
`define CBT_REL_W 3

// operation select codes
`define CBT_OP_CMP_INT 4'h0
`define CBT_OP_CMP_DINT 4'h1
`define CBT_OP_CMP_REAL 4'h2
`define CBT_OP_BLK_ADD 4'h3
`define CBT_OP_BLK_SUB 4'h4
`define CBT_OP_BLK_CMP 4'h5
`define CBT_OP_CLAMP 4'h6
`define CBT_OP_DEAD_BAND_OP 4'h7
`define CBT_OP_ZONE 4'h8

// block compare relation codes
`define CBT_REL_EQ 3'h0
`define CBT_REL_GT 3'h1
`define CBT_REL_LT 3'h2
`define CBT_REL_NE 3'h3
`define CBT_REL_LE 3'h4
`define CBT_REL_GE 3'h5

// one-hot compare result positions: lowest is less-than
`define CBT_RES_LT 0
`define CBT_RES_EQ 1
`define CBT_RES_GT 2
`define CBT_RES_NONE 3'h0
`define CBT_RES_LT_HOT 3'h1
`define CBT_RES_EQ_HOT 3'h2
`define CBT_RES_GT_HOT 3'h4

// real operand layout
`define CBT_REAL_SIGN 31
`define CBT_REAL_MAG 30:0
`define CBT_REAL_SIGN_FLIP 32'h8000_0000
`define CBT_REAL_MAG_ZERO 31'h0000_0000

`define CBT_ZERO_WORD 16'h0000
`define CBT_ZERO_CNT 9'h000
`define CBT_ONE_CNT 9'h001
`define CBT_ONE_WORD 16'h0001

`endif

// ---- cbt_ops.v ----
// compare-and-set, batch data and table operation datapath
// Notes on behaviour
// - an enabled integer compare sets exactly one of less, equal or greater result bits.
// - the double-integer compare does the same on 32-bit signed operands.
// - the real compare does the same on single-precision operands.
// - block add writes first-block word plus second-block word to consecutive destinations.
// - for block add and subtract a constant second operand meets every first-block word.
// - block operations never raise the carry flag on overflow and leave it untouched.
// - block subtract writes first-block word minus second-block word to consecutive destinations.
// - block compare offers equal, greater, less, not equal, less-or-equal, greater-or-equal.
// - block compare writes each boolean result to consecutive destination bits.
// - a constant first operand of block compare meets every second-block word.
// - clamp gives the lower limit below it and the upper limit above it.
// - dead band gives input minus lower below, input minus upper above, zero inside.
// - dead band result is zero for inputs between the bounds inclusive.
// - zone adds the negative offset to negative input, the positive to positive, zero for zero.
`include "cbt_ops_map.vh"

module cbt_ops (
   input wire CORE_CLK,
   input wire RST_N,
   input wire OP_EN,
   input wire OP_START,
   input wire [`CBT_OP_W-1:0] OP_SEL,
   input wire [`CBT_REL_W-1:0] REL_SEL,
   input wire CONST_MODE,
   input wire [`CBT_CNT_W-1:0] ELEM_COUNT,
   input wire [`CBT_WORD_W-1:0] DEST_BASE,
   input wire [`CBT_DINT_W-1:0] OPND_A,
   input wire [`CBT_DINT_W-1:0] OPND_B,
   input wire [`CBT_WORD_W-1:0] OPND_C,
   input wire ELEM_VALID,
   input wire [`CBT_WORD_W-1:0] ELEM_A,
   input wire [`CBT_WORD_W-1:0] ELEM_B,
   output reg [2:0] CMP_BITS,
   output reg CMP_VALID,
   output reg WR_EN,
   output reg [`CBT_WORD_W-1:0] WR_ADDR,
   output reg [`CBT_WORD_W-1:0] WR_DATA,
   output reg BIT_WR_EN,
   output reg BIT_WR_DATA,
   output reg ALL_TRUE_FLAG,
   output reg CARRY_WR,
   output reg BUSY,
   output reg DONE
);

   localparam ST_IDLE = 1'b0;
   localparam ST_RUN = 1'b1;

   reg state;
   reg [`CBT_OP_W-1:0] blk_op;
   reg [`CBT_REL_W-1:0] blk_rel;
   reg blk_const;
   reg [`CBT_WORD_W-1:0] blk_kval;
   reg [`CBT_CNT_W-1:0] blk_left;
   reg [`CBT_WORD_W-1:0] blk_addr;
   reg blk_and;

   // single-shot compares
   wire signed [`CBT_WORD_W-1:0] int_a = OPND_A[`CBT_WORD_W-1:0];
   wire signed [`CBT_WORD_W-1:0] int_b = OPND_B[`CBT_WORD_W-1:0];
   wire signed [`CBT_DINT_W-1:0] dint_a = OPND_A;
   wire signed [`CBT_DINT_W-1:0] dint_b = OPND_B;

   // reals map to an ordered unsigned key; both zeros fold to one key
   wire a_zero = (OPND_A[`CBT_REAL_MAG] == `CBT_REAL_MAG_ZERO);
   wire b_zero = (OPND_B[`CBT_REAL_MAG] == `CBT_REAL_MAG_ZERO);
   wire [`CBT_DINT_W-1:0] key_a = a_zero ? `CBT_REAL_SIGN_FLIP :
      (OPND_A[`CBT_REAL_SIGN] ? ~OPND_A : (OPND_A ^ `CBT_REAL_SIGN_FLIP));
   wire [`CBT_DINT_W-1:0] key_b = b_zero ? `CBT_REAL_SIGN_FLIP :
      (OPND_B[`CBT_REAL_SIGN] ? ~OPND_B : (OPND_B ^ `CBT_REAL_SIGN_FLIP));

   reg cmp_lt;
   reg cmp_eq;
   reg [2:0] next_cmp_bits;

   always @* begin
      case (OP_SEL)
         `CBT_OP_CMP_DINT: begin
            cmp_lt = (dint_a < dint_b);
            cmp_eq = (dint_a == dint_b);
         end
         `CBT_OP_CMP_REAL: begin
            cmp_lt = (key_a < key_b);
            cmp_eq = (key_a == key_b);
         end
         default: begin
            cmp_lt = (int_a < int_b);
            cmp_eq = (int_a == int_b);
         end
      endcase
      if (cmp_lt)
         next_cmp_bits = `CBT_RES_LT_HOT;
      else if (cmp_eq)
         next_cmp_bits = `CBT_RES_EQ_HOT;
      else
         next_cmp_bits = `CBT_RES_GT_HOT;
   end

   // table operations on 16-bit signed words
   wire signed [`CBT_WORD_W-1:0] lo = OPND_A[`CBT_WORD_W-1:0];
   wire signed [`CBT_WORD_W-1:0] hi = OPND_B[`CBT_WORD_W-1:0];
   wire signed [`CBT_WORD_W-1:0] inp = OPND_C;
   wire signed [`CBT_WORD_W-1:0] zero_w = `CBT_ZERO_WORD;

   reg [`CBT_WORD_W-1:0] next_table;

   always @* begin
      case (OP_SEL)
         `CBT_OP_CLAMP: begin
            if (inp < lo)
               next_table = lo;
            else if (inp > hi)
               next_table = hi;
            else
               next_table = inp;
         end
         `CBT_OP_DEAD_BAND_OP: begin
            // results wrap at 16 bits, as in the element store
            if (inp < lo)
               next_table = inp - lo;
            else if (inp > hi)
               next_table = inp - hi;
            else
               next_table = `CBT_ZERO_WORD;
         end
         `CBT_OP_ZONE: begin
            if (inp < zero_w)
               next_table = inp + lo;
            else if (inp > zero_w)
               next_table = inp + hi;
            else
               next_table = `CBT_ZERO_WORD;
         end
         default: begin
            next_table = `CBT_ZERO_WORD;
         end
      endcase
   end

   // block element datapath
   wire [`CBT_WORD_W-1:0] add_rhs = blk_const ? blk_kval : ELEM_B;
   wire [`CBT_WORD_W-1:0] sum_w = ELEM_A + add_rhs;
   wire [`CBT_WORD_W-1:0] diff_w = ELEM_A - add_rhs;
   wire signed [`CBT_WORD_W-1:0] bc_a = blk_const ? blk_kval : ELEM_A;
   wire signed [`CBT_WORD_W-1:0] bc_b = ELEM_B;

   reg rel_hit;

   always @* begin
      case (blk_rel)
         `CBT_REL_EQ: rel_hit = (bc_a == bc_b);
         `CBT_REL_GT: rel_hit = (bc_a > bc_b);
         `CBT_REL_LT: rel_hit = (bc_a < bc_b);
         `CBT_REL_NE: rel_hit = (bc_a != bc_b);
         `CBT_REL_LE: rel_hit = (bc_a <= bc_b);
         `CBT_REL_GE: rel_hit = (bc_a >= bc_b);
         default: rel_hit = 1'b0;
      endcase
   end

   wire is_block = (OP_SEL == `CBT_OP_BLK_ADD) ||
      (OP_SEL == `CBT_OP_BLK_SUB) || (OP_SEL == `CBT_OP_BLK_CMP);
   wire is_cmp = (OP_SEL == `CBT_OP_CMP_INT) ||
      (OP_SEL == `CBT_OP_CMP_DINT) || (OP_SEL == `CBT_OP_CMP_REAL);
   wire is_table = (OP_SEL == `CBT_OP_CLAMP) ||
      (OP_SEL == `CBT_OP_DEAD_BAND_OP) || (OP_SEL == `CBT_OP_ZONE);
   wire go = OP_EN && OP_START;
   wire last_elem = (blk_left == `CBT_ONE_CNT);
   wire step = OP_EN && ELEM_VALID;

   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= ST_IDLE;
         blk_op <= `CBT_OP_BLK_ADD;
         blk_rel <= `CBT_REL_EQ;
         blk_const <= 1'b0;
         blk_kval <= `CBT_ZERO_WORD;
         blk_left <= `CBT_ZERO_CNT;
         blk_addr <= `CBT_ZERO_WORD;
         blk_and <= 1'b0;
         CMP_BITS <= `CBT_RES_NONE;
         CMP_VALID <= 1'b0;
         WR_EN <= 1'b0;
         WR_ADDR <= `CBT_ZERO_WORD;
         WR_DATA <= `CBT_ZERO_WORD;
         BIT_WR_EN <= 1'b0;
         BIT_WR_DATA <= 1'b0;
         ALL_TRUE_FLAG <= 1'b0;
         CARRY_WR <= 1'b0;
         BUSY <= 1'b0;
         DONE <= 1'b0;
      end else begin
         CMP_VALID <= 1'b0;
         WR_EN <= 1'b0;
         BIT_WR_EN <= 1'b0;
         DONE <= 1'b0;
         // the carry flag is never written by this block
         CARRY_WR <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (go && is_cmp) begin
                  CMP_BITS <= next_cmp_bits;
                  CMP_VALID <= 1'b1;
                  DONE <= 1'b1;
               end else if (go && is_table) begin
                  WR_EN <= 1'b1;
                  WR_ADDR <= DEST_BASE;
                  WR_DATA <= next_table;
                  DONE <= 1'b1;
               end else if (go && is_block) begin
                  blk_op <= OP_SEL;
                  blk_rel <= REL_SEL;
                  blk_const <= CONST_MODE;
                  // a constant is the second operand for add and subtract
                  // but the first operand for compare
                  blk_kval <= (OP_SEL == `CBT_OP_BLK_CMP) ?
                     OPND_A[`CBT_WORD_W-1:0] : OPND_B[`CBT_WORD_W-1:0];
                  blk_left <= ELEM_COUNT;
                  blk_addr <= DEST_BASE;
                  blk_and <= 1'b1;
                  if (OP_SEL == `CBT_OP_BLK_CMP)
                     ALL_TRUE_FLAG <= 1'b0;
                  if (ELEM_COUNT == `CBT_ZERO_CNT) begin
                     DONE <= 1'b1;
                  end else begin
                     state <= ST_RUN;
                     BUSY <= 1'b1;
                  end
               end
            end
            ST_RUN: begin
               if (!OP_EN) begin
                  // losing enable mid-block abandons the run unwritten
                  state <= ST_IDLE;
                  BUSY <= 1'b0;
               end else if (step) begin
                  WR_ADDR <= blk_addr;
                  if (blk_op == `CBT_OP_BLK_CMP) begin
                     BIT_WR_EN <= 1'b1;
                     BIT_WR_DATA <= rel_hit;
                     blk_and <= blk_and & rel_hit;
                  end else begin
                     WR_EN <= 1'b1;
                     WR_DATA <= (blk_op == `CBT_OP_BLK_SUB) ? diff_w : sum_w;
                  end
                  blk_addr <= blk_addr + `CBT_ONE_WORD;
                  blk_left <= blk_left - `CBT_ONE_CNT;
                  if (last_elem) begin
                     state <= ST_IDLE;
                     BUSY <= 1'b0;
                     DONE <= 1'b1;
                     if (blk_op == `CBT_OP_BLK_CMP)
                        ALL_TRUE_FLAG <= blk_and & rel_hit;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
               BUSY <= 1'b0;
            end
         endcase
      end
   end

endmodule

// ---- cbt_ops_sva.sv ----
// port assertions for the compare, batch and table datapath
`include "cbt_ops_map.vh"
module cbt_ops_sva (
   input wire CORE_CLK,
   input wire RST_N,
   input wire OP_EN,
   input wire OP_START,
   input wire [3:0] OP_SEL,
   input wire CONST_MODE,
   input wire [15:0] DEST_BASE,
   input wire [31:0] OPND_A,
   input wire [31:0] OPND_B,
   input wire [15:0] OPND_C,
   input wire ELEM_VALID,
   input wire [15:0] ELEM_A,
   input wire [15:0] ELEM_B,
   input wire [2:0] CMP_BITS,
   input wire CMP_VALID,
   input wire WR_EN,
   input wire [15:0] WR_ADDR,
   input wire [15:0] WR_DATA,
   input wire BIT_WR_EN,
   input wire CARRY_WR,
   input wire BUSY
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   wire go = OP_EN && OP_START && !BUSY;
   wire signed [15:0] lo = OPND_A[15:0];
   wire signed [15:0] hi = OPND_B[15:0];
   wire signed [15:0] x = OPND_C;
   a_cmp_onehot: assert property (CMP_VALID |-> $onehot(CMP_BITS))
      else $error("compare result not one-hot");
   a_cmp_answer: assert property (
      go && OP_SEL <= `CBT_OP_CMP_REAL |=> CMP_VALID && !WR_EN)
      else $error("compare answer missing");
   a_carry_quiet: assert property (CARRY_WR == 1'b0)
      else $error("carry written");
   a_no_write: assert property (!OP_EN |=> !WR_EN && !BIT_WR_EN)
      else $error("write without enable");
   a_tbl_addr: assert property (
      go && OP_SEL >= `CBT_OP_CLAMP && OP_SEL <= `CBT_OP_ZONE
      |=> WR_EN && WR_ADDR == $past(DEST_BASE))
      else $error("table write missing");
   a_clamp_low: assert property (
      go && OP_SEL == `CBT_OP_CLAMP && x < lo |=> WR_DATA == $past(lo))
      else $error("clamp low wrong");
   a_clamp_pass: assert property (
      go && OP_SEL == `CBT_OP_CLAMP && x >= lo && x <= hi
      |=> WR_DATA == $past(OPND_C))
      else $error("clamp pass wrong");
   a_dead_band_op_zero: assert property (
      go && OP_SEL == `CBT_OP_DEAD_BAND_OP && x >= lo && x <= hi |=> WR_DATA == 0)
      else $error("dead band not zero");
   a_zone_zero: assert property (
      go && OP_SEL == `CBT_OP_ZONE && x == 0 |=> WR_EN && WR_DATA == 0)
      else $error("zone zero wrong");
   a_blk_add: assert property (
      BUSY && OP_EN && ELEM_VALID && OP_SEL == `CBT_OP_BLK_ADD && !CONST_MODE
      |=> WR_EN && WR_DATA == 16'($past(ELEM_A) + $past(ELEM_B)))
      else $error("block sum wrong");
endmodule
bind cbt_ops cbt_ops_sva u_sva (.*);

// ---- cbt_seq_model.sv ----
// sequencer partner streaming element pairs, optionally with stalls
module cbt_seq_model (
   input wire logic CORE_CLK,
   input wire logic BUSY,
   input wire logic SLOW,
   output logic ELEM_VALID,
   output logic [15:0] ELEM_A,
   output logic [15:0] ELEM_B
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] s = 16'h5a3c;
   initial begin
      ELEM_VALID = 0;
      ELEM_A = 0;
      ELEM_B = 0;
   end
   always @(negedge CORE_CLK) begin
      s = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
      ELEM_VALID = BUSY && !(SLOW && s[0]);
      // idle bus shows inverted data so stale values never pass
      ELEM_A = ELEM_VALID ? s : ~ELEM_A;
      ELEM_B = ELEM_VALID ? {s[7:0], s[15:8]} ^ 16'h00ff : ~ELEM_B;
   end
endmodule

// ---- tb_compare_batch_table_ops.sv ----
// self-checking bench for the compare, batch and table datapath
`include "cbt_ops_map.vh"
module tb_compare_batch_table_ops;
   timeunit 1ns;
   timeprecision 1ns;
   logic CORE_CLK = 0, RST_N = 0, OP_EN = 0, OP_START = 0, CONST_MODE = 0;
   logic SLOW = 0, ELEM_VALID, CMP_VALID, WR_EN, BIT_WR_EN, BIT_WR_DATA;
   logic ALL_TRUE_FLAG, CARRY_WR, BUSY, DONE, all;
   logic [3:0] OP_SEL = 0;
   logic [2:0] REL_SEL = 0, CMP_BITS, cexp;
   logic [8:0] ELEM_COUNT = 0;
   logic [15:0] DEST_BASE = 0, OPND_C = 0, ELEM_A, ELEM_B, WR_ADDR, WR_DATA;
   logic [15:0] a, b, qa[$], qb[$];
   logic [31:0] OPND_A = 0, OPND_B = 0, r = 32'h780e;
   int n_mismatch = 0, tests_run = 0, k, i, w, cyc = 0;
   cbt_ops u_dut (.*);
   cbt_seq_model u_seq (.*);
   initial forever #10 CORE_CLK = ~CORE_CLK;
   function automatic logic [31:0] nx(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [2:0] c3(logic signed [33:0] p, q);
      return p < q ? 3'h1 : p == q ? 3'h2 : 3'h4;
   endfunction
   // order key for single floats; both zeros map to one key
   function automatic logic [33:0] key(logic [31:0] v);
      if (v[30:0] == 0) return 34'h1_0000_0000;
      return v[31] ? {2'b00, ~v} : {2'b01, v};
   endfunction
   function automatic logic [15:0] tbl(logic [3:0] op,
         logic signed [15:0] lo, hi, v);
      if (op == `CBT_OP_CLAMP) return v < lo ? lo : v > hi ? hi : v;
      if (op == `CBT_OP_DEAD_BAND_OP) return v < lo ? v - lo : v > hi ? v - hi : 0;
      return v < 0 ? v + lo : v > 0 ? v + hi : 0;
   endfunction
   function automatic logic rel(logic [2:0] s, logic signed [15:0] p, q);
      case (s)
         0: return p == q;
         1: return p > q;
         2: return p < q;
         3: return p != q;
         4: return p <= q;
         default: return p >= q;
      endcase
   endfunction
   task chk(input logic [15:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // start is left high so single-shot ops can follow back to back
   task start;
      OP_EN = 1;
      OP_START = 1;
      @(negedge CORE_CLK);
   endtask
   task blk(input logic [3:0] op, input logic cm, input logic [8:0] n);
      OP_SEL = op;
      CONST_MODE = cm;
      ELEM_COUNT = n;
      r = nx(r);
      DEST_BASE = r[15:0];
      k = 0;
      all = 1;
      start;
      OP_START = 0;
      for (w = 0; w < 60 && !DONE; w++) @(negedge CORE_CLK);
      @(negedge CORE_CLK);
      chk(k, n);
      if (op == `CBT_OP_BLK_CMP) chk(ALL_TRUE_FLAG, all && n != 0);
   endtask
   always @(posedge CORE_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_mismatch++;
         wrap_up;
      end
   end
   // element results are read at the edge after the one that launched them
   always @(posedge CORE_CLK) begin
      if ((WR_EN || BIT_WR_EN) && qa.size() > 0) begin
         a = qa.pop_front();
         b = qb.pop_front();
         if (CONST_MODE && OP_SEL == `CBT_OP_BLK_CMP) a = OPND_A[15:0];
         if (CONST_MODE && OP_SEL != `CBT_OP_BLK_CMP) b = OPND_B[15:0];
         chk(WR_ADDR, DEST_BASE + k);
         if (OP_SEL == `CBT_OP_BLK_CMP) begin
            all &= rel(REL_SEL, a, b);
            chk({BIT_WR_EN, WR_EN, BIT_WR_DATA}, {2'b10, rel(REL_SEL, a, b)});
         end else begin
            chk(WR_DATA, OP_SEL == `CBT_OP_BLK_ADD ? a + b : a - b);
         end
         k++;
      end
      if (BUSY && OP_EN && ELEM_VALID) begin
         qa.push_back(ELEM_A);
         qb.push_back(ELEM_B);
      end
   end
   initial begin
      repeat (5) @(negedge CORE_CLK);
      RST_N = 1;
      for (i = 0; i < 60; i++) begin
         OP_SEL = i % 3;
         r = nx(r);
         OPND_A = r & 32'hbfff_ffff;
         r = nx(r);
         OPND_B = i % 5 == 0 ? OPND_A : r & 32'hbfff_ffff;
         if (i == 2) {OPND_A, OPND_B} = {32'h8000_0000, 32'h0000_0000};
         cexp = OP_SEL == 0 ? c3($signed(OPND_A[15:0]), $signed(OPND_B[15:0]))
            : OP_SEL == 1 ? c3($signed(OPND_A), $signed(OPND_B))
            : c3(key(OPND_A), key(OPND_B));
         start;
         chk({CMP_VALID, DONE, CMP_BITS}, {2'b11, cexp});
      end
      for (i = 0; i < 60; i++) begin
         OP_SEL = `CBT_OP_CLAMP + i % 3;
         r = nx(r);
         OPND_A = $signed(r[15:0]) > $signed(r[31:16]) ? r[31:16] : r[15:0];
         OPND_B = $signed(r[15:0]) > $signed(r[31:16]) ? r[15:0] : r[31:16];
         r = nx(r);
         OPND_C = i % 4 == 0 ? OPND_A[15:0] : i % 4 == 1 ? OPND_B[15:0]
            : i % 4 == 2 ? 16'h0000 : r[15:0];
         DEST_BASE = r[31:16];
         start;
         chk({WR_EN, DONE}, 2'b11);
         chk(WR_ADDR, DEST_BASE);
         chk(WR_DATA, tbl(OP_SEL, OPND_A, OPND_B, OPND_C));
      end
      for (i = 0; i < 24; i++) begin
         SLOW = i[0];
         REL_SEL = i / 4;
         r = nx(r);
         OPND_A = r;
         OPND_B = r >> 7;
         blk(`CBT_OP_BLK_ADD + i % 3, i[3] ^ i[1], i % 9);
      end
      REL_SEL = `CBT_REL_LE;
      OPND_A = 32'h0000_8000;
      blk(`CBT_OP_BLK_CMP, 1, 8);
      blk(`CBT_OP_BLK_CMP, 1, 0);
      SLOW = 0;
      OP_SEL = `CBT_OP_BLK_ADD;
      ELEM_COUNT = 8;
      start;
      OP_START = 0;
      @(negedge CORE_CLK);
      // drop enable mid-run, then offer a start while enable is low
      OP_EN = 0;
      OP_START = 1;
      @(negedge CORE_CLK);
      chk({BUSY, DONE, WR_EN, BIT_WR_EN}, 0);
      @(negedge CORE_CLK);
      OP_START = 0;
      chk({BUSY, DONE, WR_EN, CMP_VALID}, 0);
      chk(CARRY_WR, 0);
      wrap_up;
   end
endmodule
